// ==== tb/core_storage_model.sv ====
/* core storage model: 16 words, prompt or slow acknowledge.
   assumes requests are held until acknowledged. */
`timescale 1ns/1ps

module core_storage_model (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    // requests from the unit
    input  wire        rd_i,
    input  wire        wr_i,
    input  wire [14:0] addr_i,
    input  wire [35:0] wdata_i,
    input  wire        slow_i,
    // answer
    output reg  [35:0] rdata_o,
    output reg         ack_o
);
reg [35:0] mem [0:15];
reg [1:0]  wait_r;
// outside the ack cycle read data toggles so stale data is never mistaken
always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        ack_o   <= 1'b0;
        rdata_o <= 36'h0;
        wait_r  <= 2'h0;
    end else if ((rd_i | wr_i) && !ack_o && wait_r >= (slow_i ? 2'h3 : 2'h0)) begin
        ack_o  <= 1'b1;
        wait_r <= 2'h0;
        if (rd_i)
            rdata_o <= mem[addr_i[3:0]];
        if (wr_i)
            mem[addr_i[3:0]] <= wdata_i;
    end else begin
        ack_o   <= 1'b0;
        rdata_o <= ~rdata_o;
        if ((rd_i | wr_i) && !ack_o)
            wait_r <= wait_r + 2'h1;
    end
end
endmodule // core_storage_model

// ==== tb/logic_char_unit_sva.sv ====
/* assertions for the logic and character unit, one clock domain.
   assumes it is bound to logic_char_unit and sees only its ports. */
`timescale 1ns/1ps
`include "logic_char_defs.vh"

module logic_char_unit_sva (
    // clock and reset
    input wire        clk_i,
    input wire        rst_n_i,
    // command
    input wire        op_start_i,
    input wire [2:0]  opcode_i,
    input wire [35:0] instr_i,
    input wire        index_en_i,
    input wire [14:0] index_val_i,
    input wire        ac_load_i,
    input wire [37:0] ac_load_data_i,
    // storage
    input wire        mem_rd_o,
    input wire        mem_wr_o,
    input wire [14:0] mem_addr_o,
    input wire [35:0] mem_wdata_o,
    input wire [35:0] mem_rdata_i,
    input wire        mem_ack_i,
    // status
    input wire [37:0] ac_o,
    input wire        busy_o,
    input wire        done_o,
    input wire        ic_step_o,
    input wire [1:0]  skip_count_o,
    input wire [5:0]  char_sel_o,
    input wire        sel_invalid_o
);
////////////////////////////////////////////////////////////////////////////////
function [5:0] chr(input [35:0] w, input [2:0] s);
    chr = w[35-6*s -: 6];
endfunction
function [35:0] mrg(input [35:0] w, input [5:0] c, input [2:0] s);
    begin
        mrg = w;
        mrg[35-6*s -: 6] = c;
    end
endfunction
function [1:0] rel(input gt, input eq);
    rel = gt ? 2'h0 : (eq ? 2'h1 : 2'h2);
endfunction
////////////////////////////////////////////////////////////////////////////////
// operands seen at start and at the read, so results can be judged at done
reg  [2:0]  op_r;
reg  [37:0] a_r;
reg  [35:0] m_r;
reg  [2:0]  sel_r;
reg  [14:0] ea_r;
reg  [1:0]  n_r;
wire        chr_ok = sel_r < 3'h6;
wire [5:0]  c_w    = chr(m_r, sel_r);
wire [36:0] lv_w   = {a_r[37:36], a_r[34:0]};
// sign and magnitude: differing signs decide alone, negatives compare reversed
wire        gt_a   = (a_r[35] != m_r[35]) ? !a_r[35] :
                     (a_r[35] ? a_r[34:0] < m_r[34:0] : a_r[34:0] > m_r[34:0]);
always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        op_r  <= 3'h0;
        a_r   <= 38'h0;
        m_r   <= 36'h0;
        sel_r <= 3'h0;
        ea_r  <= 15'h0;
        n_r   <= 2'h0;
    end else begin
        if (op_start_i && !busy_o) begin
            op_r  <= opcode_i;
            a_r   <= ac_o;
            sel_r <= instr_i[20:18];
            ea_r  <= instr_i[14:0] + (index_en_i ? index_val_i : 15'h0);
            n_r   <= 2'h0;
        end else if (ic_step_o)
            n_r <= n_r + 2'h1;
        if (mem_rd_o && mem_ack_i)
            m_r <= mem_rdata_i;
    end
end
////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge clk_i); endclocking
default disable iff (!rst_n_i);
sequence s_end(logic [2:0] op);
    done_o && op_r == op;
endsequence
property p_and;
    s_end(`OP_AND) |-> {ac_o[36], ac_o[34:0]} == {a_r[36] & m_r[35], a_r[34:0] & m_r[34:0]};
endproperty
a_and: assert property (p_and) else $error("and result wrong");
property p_or;
    s_end(`OP_OR) |-> {ac_o[36], ac_o[34:0]} == {a_r[36] | m_r[35], a_r[34:0] | m_r[34:0]};
endproperty
a_or: assert property (p_or) else $error("or result wrong");
property p_compl;
    s_end(`OP_COMPL_MAG) |-> ac_o == {~a_r[37:36], a_r[35], ~a_r[34:0]};
endproperty
a_compl: assert property (p_compl) else $error("complement wrong");
property p_place;
    s_end(`OP_PLACE_CHAR) ##0 chr_ok |-> {ac_o[37:36], ac_o[34:0]} == {lv_w[36:6], c_w};
endproperty
a_place: assert property (p_place) else $error("placed character wrong");
property p_store;
    mem_wr_o |-> mem_wdata_o == mrg(m_r, a_r[5:0], sel_r) && mem_addr_o == ea_r;
endproperty
a_store: assert property (p_store) else $error("stored word wrong");
property p_arith;
    s_end(`OP_CMP_ARITH) |-> skip_count_o == rel(gt_a, a_r[35:0] == m_r);
endproperty
a_arith: assert property (p_arith) else $error("arith compare steps wrong");
property p_logic;
    s_end(`OP_CMP_LOGIC) |-> skip_count_o == rel(lv_w > {1'b0, m_r}, lv_w == {1'b0, m_r});
endproperty
a_logic: assert property (p_logic) else $error("logic compare steps wrong");
property p_cchar;
    s_end(`OP_CMP_CHAR) ##0 chr_ok |-> skip_count_o == rel(a_r[5:0] > c_w, a_r[5:0] == c_w);
endproperty
a_cchar: assert property (p_cchar) else $error("char compare steps wrong");
property p_steps;
    done_o |-> n_r + ic_step_o == skip_count_o;
endproperty
a_steps: assert property (p_steps) else $error("step pulses differ from count");
property p_sel;
    $rose(mem_rd_o) ##0 op_r >= `OP_PLACE_CHAR ##0 chr_ok |-> char_sel_o == 6'h1 << sel_r;
endproperty
a_sel: assert property (p_sel) else $error("character select wrong");
property p_addr;
    mem_rd_o |-> mem_addr_o == ea_r;
endproperty
a_addr: assert property (p_addr) else $error("operand address wrong");
property p_inval;
    done_o && op_r >= `OP_PLACE_CHAR && !chr_ok |-> sel_invalid_o && ac_o == a_r;
endproperty
a_inval: assert property (p_inval) else $error("undefined selector not inert");
endmodule // logic_char_unit_sva

// ==== tb/logic_char_unit_tb.sv ====
/* self-checking bench for the logic and character unit.
   assumes core_storage_model as storage and the checker bound below. */
`timescale 1ns/1ps
`include "logic_char_defs.vh"

module logic_char_unit_tb;
reg         clk = 1'b0, rst_n = 1'b0, start = 1'b0, idx_en = 1'b0, ld = 1'b0, slow = 1'b0;
reg  [2:0]  op = 3'h0;
reg  [35:0] ins = 36'h0;
reg  [14:0] idx = 15'h0;
reg  [37:0] ld_data = 38'h0;
wire        rd, wr, ack, busy, done, step, inval;
wire [14:0] addr;
wire [35:0] wdata, rdata;
wire [37:0] ac;
wire [1:0]  skip;
wire [5:0]  csel;
integer     n_errors = 0, n_checks = 0, cyc = 0, steps;

always #50 clk = ~clk;

logic_char_unit logic_char_unit_inst (.clk_i(clk), .rst_n_i(rst_n), .op_start_i(start),
    .opcode_i(op), .instr_i(ins), .index_en_i(idx_en), .index_val_i(idx), .ac_load_i(ld),
    .ac_load_data_i(ld_data), .mem_rd_o(rd), .mem_wr_o(wr), .mem_addr_o(addr),
    .mem_wdata_o(wdata), .mem_rdata_i(rdata), .mem_ack_i(ack), .ac_o(ac), .busy_o(busy),
    .done_o(done), .ic_step_o(step), .skip_count_o(skip), .char_sel_o(csel),
    .sel_invalid_o(inval));
core_storage_model core_storage_model_inst (.clk_i(clk), .rst_n_i(rst_n), .rd_i(rd),
    .wr_i(wr), .addr_i(addr), .wdata_i(wdata), .slow_i(slow), .rdata_o(rdata), .ack_o(ack));
////////////////////////////////////////////////////////////////////////////////
task chk(input [63:0] got, input [63:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
endtask
task tally_and_finish;
    begin
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
endtask
// presets the operand word, loads the accumulator, runs one op to done
task run(input [2:0] o, input [35:0] w, input [37:0] a, input [35:0] m);
    integer k;
    begin
        repeat (2) @(posedge clk);
        core_storage_model_inst.mem[w[3:0] + (idx_en ? idx[3:0] : 4'h0)] = m;
        ld      <= 1'b1;
        ld_data <= a;
        @(posedge clk);
        ld    <= 1'b0;
        start <= 1'b1;
        op    <= o;
        ins   <= w;
        @(posedge clk);
        start <= 1'b0;
        steps = 0;
        for (k = 0; k < 60 && done !== 1'b1; k = k + 1) begin
            @(negedge clk);
            steps = steps + step;
        end
        chk(done, 1'b1);
        chk(steps, skip);
    end
endtask
task cmp(input [2:0] o, input [37:0] a, input [35:0] m, input [1:0] e);
    begin
        run(o, 36'h0, a, m);
        chk(skip, e);
    end
endtask
////////////////////////////////////////////////////////////////////////////////
task t_logic;
    begin
        idx_en <= 1'b1;
        idx    <= 15'h0005;
        run(`OP_AND, 36'h3, 38'h3c_f0f0_f0f0, 36'h8_ff00_ff00);
        chk(ac, 38'h38_f000_f000);
        run(`OP_AND, 36'h3, 38'h3c_f0f0_f0f0, 36'h7_ffff_ffff);
        chk(ac, 38'h2c_f0f0_f0f0);
        run(`OP_OR, 36'h3, 38'h3c_f0f0_f0f0, 36'h8_ff00_ff00);
        chk(ac, 38'h3c_fff0_fff0);
        @(posedge clk) idx_en <= 1'b0;
    end
endtask
task t_cmp;
    begin
        slow <= 1'b1;
        cmp(`OP_CMP_ARITH, 38'h00_0000_0005, 36'h0_0000_0003, 2'h0);
        cmp(`OP_CMP_ARITH, 38'h00_0000_0005, 36'h0_0000_0005, 2'h1);
        cmp(`OP_CMP_ARITH, 38'h00_0000_0003, 36'h0_0000_0005, 2'h2);
        cmp(`OP_CMP_ARITH, 38'h08_0000_0005, 36'h8_0000_0003, 2'h2);
        cmp(`OP_CMP_ARITH, 38'h08_0000_0003, 36'h8_0000_0005, 2'h0);
        cmp(`OP_CMP_ARITH, 38'h00_0000_0005, 36'h8_0000_0003, 2'h0);
        cmp(`OP_CMP_ARITH, 38'h08_0000_0003, 36'h0_0000_0005, 2'h2);
        slow <= 1'b0;
        cmp(`OP_CMP_LOGIC, 38'h20_0000_0000, 36'hf_ffff_ffff, 2'h0);
        cmp(`OP_CMP_LOGIC, 38'h17_ffff_ffff, 36'hf_ffff_ffff, 2'h1);
        cmp(`OP_CMP_LOGIC, 38'h0f_ffff_ffff, 36'hf_ffff_ffff, 2'h2);
        run(`OP_COMPL_MAG, 36'h0, 38'h2a_5a5a_1234, 36'h0);
        chk(ac, 38'h1d_a5a5_edcb);
    end
endtask
// every selector, including the two undefined ones, for all three char ops
task t_chars;
    reg [35:0] w, x, iw;
    reg [5:0]  c;
    integer    s;
    begin
        w = {6'h01, 6'h12, 6'h23, 6'h34, 6'h2d, 6'h3e};
        for (s = 0; s < 8; s = s + 1) begin
            slow <= s[0];
            iw = {13'h0, 2'h3, s[2:0], 18'h0};
            c = (s < 6) ? w[35-6*s -: 6] : 6'h12;
            x = w;
            if (s < 6)
                x[35-6*s -: 6] = 6'h12;
            run(`OP_PLACE_CHAR, iw, 38'h3f_ffff_ffd2, w);
            chk({ac[37:36], ac[34:0]}, s < 6 ? {31'h7fff_ffff, c} : 37'h1f_ffff_ffd2);
            chk(inval, s > 5);
            run(`OP_STORE_CHAR, iw, 38'h3f_ffff_ffd2, w);
            chk(core_storage_model_inst.mem[0], x);
            run(`OP_CMP_CHAR, iw, 38'h3f_ffff_ffd2, w);
            chk(skip, s > 5 ? 0 : (c < 6'h12 ? 0 : (c == 6'h12 ? 1 : 2)));
        end
    end
endtask
////////////////////////////////////////////////////////////////////////////////
always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
        n_errors = n_errors + 1;
        tally_and_finish;
    end
end
initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_logic;
    t_cmp;
    t_chars;
    tally_and_finish;
end
endmodule // logic_char_unit_tb

bind logic_char_unit logic_char_unit_sva logic_char_unit_sva_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .op_start_i(op_start_i), .opcode_i(opcode_i), .instr_i(instr_i),
    .index_en_i(index_en_i), .index_val_i(index_val_i), .ac_load_i(ac_load_i),
    .ac_load_data_i(ac_load_data_i), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
    .mem_ack_i(mem_ack_i), .ac_o(ac_o), .busy_o(busy_o), .done_o(done_o),
    .ic_step_o(ic_step_o), .skip_count_o(skip_count_o), .char_sel_o(char_sel_o),
    .sel_invalid_o(sel_invalid_o));

// ==== verilog/logic_char_defs.vh ====
/*
 * constants for the logical and character operations unit:
 * operation codes, sequencer states, word field positions.
 * assumes plain verilog-2005 and inclusion by bare name.
 */
`ifndef LOGIC_CHAR_DEFS_VH
`define LOGIC_CHAR_DEFS_VH

// operation codes presented by the sequencer
`define OP_AND          3'h0
`define OP_OR           3'h1
`define OP_CMP_ARITH    3'h2
`define OP_CMP_LOGIC    3'h3
`define OP_COMPL_MAG    3'h4
`define OP_PLACE_CHAR   3'h5
`define OP_STORE_CHAR   3'h6
`define OP_CMP_CHAR     3'h7

// sequencer states
`define ST_IDLE         3'h0
`define ST_ADDR         3'h1
`define ST_READ         3'h2
`define ST_PASS1        3'h3
`define ST_PASS2        3'h4
`define ST_WRITE        3'h5
`define ST_STEP         3'h6
`define ST_DONE         3'h7

// accumulator layout: [37]=Q [36]=P [35]=S [34:0]=bits 1..35
`define AC_Q            37
`define AC_P            36
`define AC_S            35
// word layout: [35]=S, word bit n sits at index 35-n
`define W_SIGN          35
// instruction bits 13..17 (position field) and 15..17 (selector)
`define INS_POS_HI      22
`define INS_POS_LO      18
`define INS_BASE_HI     14
`define INS_BASE_LO     0

// adder carry taps: overflow position for 35 / 37 bit passes, position 30
`define TAP_ARITH       35
`define TAP_LOGIC       37
`define TAP_CHAR        6

// reset values
`define AC_RST          38'h0
`define WORD_RST        36'h0
`define ADDR_RST        15'h0

`endif

// ==== verilog/logic_char_unit.v ====
/*
 * logical and 6-bit character operations datapath: and, or,
 * arithmetic compare, logical compare, complement magnitude, place,
 * store and compare character, with skip stepping of the counter.
 * assumes a sequencer on the same clock issues op_start_i with a
 * stable instruction word, and storage answers with mem_ack_i.
 */
// Overview of operation
// - and leaves 1 in positions P..35 only where accumulator and memory both hold 1.
// - accumulator P is anded with memory sign and returned into P.
// - or sets result P..35 to 1 where either operand holds 1.
// - arithmetic compare pass one: negative accumulator steps when no overflow carry.
// - pass one: positive memory operand steps on carry, negative memory never does.
// - pass two repeats the add with a forced 1 into bit 35, steps on carry.
// - arithmetic compare steps zero if greater, once if equal, twice if smaller.
// - logical compare sees Q, P, 1..35 unsigned against full 36-bit word.
// - logical compare uses ones then twos complement, stepping on each carry.
// - logical compare steps zero if larger, once if equal, twice if smaller.
// - complement magnitude inverts Q, P, 1..35 through adder, sign unchanged.
// - selector in instruction bits 15..17 picks characters S-5 through 30-35.
// - instruction bits 13..17 load position register, bits 15..17 decode one-of-six.
// - place character puts selected character in 30..35, keeps Q, P, 1..29.
// - store character merges accumulator 30..35 into the word and writes it back.
// - compare character adds character to ones complement, steps on 30 carry.
// - second pass uses twos complement; steps zero, one or two as for compares.
// - each extra counter step tells the sequencer to skip one instruction.
// - operand address is base plus index in adder positions 21..35.
`timescale 1ns/1ps
`include "logic_char_defs.vh"

module logic_char_unit (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    // command from the sequencer
    input  wire        op_start_i,
    input  wire [2:0]  opcode_i,
    input  wire [35:0] instr_i,
    input  wire        index_en_i,
    input  wire [14:0] index_val_i,
    // direct accumulator load
    input  wire        ac_load_i,
    input  wire [37:0] ac_load_data_i,
    // core storage
    output reg         mem_rd_o,
    output reg         mem_wr_o,
    output reg  [14:0] mem_addr_o,
    output reg  [35:0] mem_wdata_o,
    input  wire [35:0] mem_rdata_i,
    input  wire        mem_ack_i,
    // status back to the sequencer
    output reg  [37:0] ac_o,
    output reg         busy_o,
    output reg         done_o,
    output reg         ic_step_o,
    output reg  [1:0]  skip_count_o,
    output reg  [5:0]  char_sel_o,
    output reg         sel_invalid_o
);

    ////////////////////////////////////////////////////////////////////
    // state
    reg [2:0]  state_r;
    reg [2:0]  state_nxt;
    reg [2:0]  op_r;
    reg [14:0] base_r;
    reg        idx_en_r;
    reg [14:0] idx_r;
    reg [4:0]  pos_r;
    reg [37:0] main_operand_r;
    reg [35:0] mem_data_r;
    reg        carry1_r;
    reg [1:0]  steps_r;

    // adder operands
    reg  [37:0] add_a;
    reg  [37:0] add_b;
    reg         add_cin;
    wire [38:0] add_sum;
    reg         carry;

    // character selection
    reg  [5:0]  sel_oh;
    reg  [5:0]  mem_char;
    reg  [35:0] merged;
    wire        sel_bad;
    wire        is_char_op;
    integer     k;

    ////////////////////////////////////////////////////////////////////
    // one-of-six character decode from the position register

    assign is_char_op = (op_r == `OP_PLACE_CHAR) || (op_r == `OP_STORE_CHAR) ||
                        (op_r == `OP_CMP_CHAR);
    assign sel_bad    = is_char_op && (pos_r[2:1] == 2'h3);

    // selector 110 or 111 matches no slot, so nothing is picked or merged
    always @* begin
        sel_oh   = 6'h00;
        mem_char = 6'h00;
        merged   = mem_data_r;
        for (k = 0; k < 6; k = k + 1) begin
            if (pos_r[2:0] == k[2:0]) begin
                sel_oh[k]           = 1'b1;
                mem_char            = mem_data_r[35-6*k -: 6];
                merged[35-6*k -: 6] = main_operand_r[5:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // shared adder and its operand steering

    word_adder #(
        .WIDTH (38)
    ) u_adder (
        .a_i   (add_a),
        .b_i   (add_b),
        .cin_i (add_cin),
        .sum_o (add_sum)
    );

    always @* begin
        add_a   = 38'h0;
        add_b   = 38'h0;
        add_cin = 1'b0;
        carry   = 1'b0;
        if (state_r == `ST_ADDR) begin
            add_a = {23'h0, base_r};
            add_b = {23'h0, idx_en_r ? idx_r : 15'h0};
        end else begin
            add_cin = (state_r == `ST_PASS2);
            case (op_r)
                `OP_CMP_ARITH: begin
                    add_a = {3'h0, ~main_operand_r[34:0]};
                    add_b = {3'h0, mem_data_r[34:0]};
                    carry = add_sum[`TAP_ARITH];
                end
                `OP_CMP_LOGIC: begin
                    add_a = {1'b0, ~main_operand_r[`AC_Q:`AC_P],
                             ~main_operand_r[34:0]};
                    add_b = {2'h0, mem_data_r};
                    carry = add_sum[`TAP_LOGIC];
                end
                `OP_CMP_CHAR: begin
                    add_a = {32'h0, ~main_operand_r[5:0]};
                    add_b = {32'h0, mem_char};
                    carry = add_sum[`TAP_CHAR];
                end
                `OP_COMPL_MAG: begin
                    add_a   = ~main_operand_r;
                    add_cin = 1'b0;
                end
                `OP_PLACE_CHAR: begin
                    add_a   = {main_operand_r[37:6], 6'h00};
                    add_b   = {32'h0, mem_char};
                    add_cin = 1'b0;
                end
                default: begin
                    add_a = 38'h0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // compare outcome after the second pass: lt steps twice, le once

    reg lt;
    reg le;
    always @* begin
        lt = carry1_r;
        le = carry;
        if (op_r == `OP_CMP_ARITH) begin
            case ({main_operand_r[`AC_S], mem_data_r[`W_SIGN]})
                2'h0: begin
                    lt = carry1_r;
                    le = carry;
                end
                2'h1: begin
                    lt = 1'b0;
                    le = 1'b0;
                end
                2'h2: begin
                    lt = 1'b1;
                    le = 1'b1;
                end
                default: begin
                    lt = ~carry;
                    le = ~carry1_r;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer

    always @* begin
        state_nxt = state_r;
        case (state_r)
            `ST_IDLE: begin
                if (op_start_i) begin
                    state_nxt = (opcode_i == `OP_COMPL_MAG) ? `ST_PASS1 : `ST_ADDR;
                end
            end
            `ST_ADDR:  state_nxt = `ST_READ;
            `ST_READ: begin
                if (mem_ack_i) begin
                    state_nxt = `ST_PASS1;
                end
            end
            `ST_PASS1: begin
                if (sel_bad) begin
                    state_nxt = `ST_DONE;
                end else if (op_r == `OP_STORE_CHAR) begin
                    state_nxt = `ST_WRITE;
                end else if ((op_r == `OP_CMP_ARITH) || (op_r == `OP_CMP_LOGIC) ||
                             (op_r == `OP_CMP_CHAR)) begin
                    state_nxt = `ST_PASS2;
                end else begin
                    state_nxt = `ST_DONE;
                end
            end
            `ST_PASS2: state_nxt = `ST_STEP;
            `ST_WRITE: begin
                if (mem_ack_i) begin
                    state_nxt = `ST_DONE;
                end
            end
            `ST_STEP: begin
                if (steps_r == 2'h0) begin
                    state_nxt = `ST_DONE;
                end
            end
            `ST_DONE:  state_nxt = `ST_IDLE;
            default:   state_nxt = `ST_IDLE;
        endcase
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r        <= `ST_IDLE;
            op_r           <= `OP_AND;
            base_r         <= `ADDR_RST;
            idx_en_r       <= 1'b0;
            idx_r          <= `ADDR_RST;
            pos_r          <= 5'h00;
            main_operand_r <= `AC_RST;
            mem_data_r     <= `WORD_RST;
            carry1_r       <= 1'b0;
            steps_r        <= 2'h0;
            mem_rd_o       <= 1'b0;
            mem_wr_o       <= 1'b0;
            mem_addr_o     <= `ADDR_RST;
            mem_wdata_o    <= `WORD_RST;
            ac_o           <= `AC_RST;
            busy_o         <= 1'b0;
            done_o         <= 1'b0;
            ic_step_o      <= 1'b0;
            skip_count_o   <= 2'h0;
            char_sel_o     <= 6'h00;
            sel_invalid_o  <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            done_o    <= 1'b0;
            ic_step_o <= 1'b0;
            busy_o    <= (state_nxt != `ST_IDLE);
            case (state_r)
                `ST_IDLE: begin
                    if (op_start_i) begin
                        op_r          <= opcode_i;
                        base_r        <= instr_i[`INS_BASE_HI:`INS_BASE_LO];
                        idx_en_r      <= index_en_i;
                        idx_r         <= index_val_i;
                        pos_r         <= instr_i[`INS_POS_HI:`INS_POS_LO];
                        skip_count_o  <= 2'h0;
                        sel_invalid_o <= 1'b0;
                    end else if (ac_load_i) begin
                        main_operand_r <= ac_load_data_i;
                    end
                end
                `ST_ADDR: begin
                    mem_addr_o <= add_sum[14:0];
                    mem_rd_o   <= 1'b1;
                    char_sel_o <= sel_oh;
                end
                `ST_READ: begin
                    if (mem_ack_i) begin
                        mem_rd_o   <= 1'b0;
                        mem_data_r <= mem_rdata_i;
                    end
                end
                `ST_PASS1: begin
                    carry1_r <= carry;
                    if (sel_bad) begin
                        sel_invalid_o <= 1'b1;
                    end else begin
                        case (op_r)
                            `OP_AND: begin
                                main_operand_r[`AC_P] <= main_operand_r[`AC_P] &
                                                         mem_data_r[`W_SIGN];
                                main_operand_r[34:0]  <= main_operand_r[34:0] &
                                                         mem_data_r[34:0];
                            end
                            `OP_OR: begin
                                main_operand_r[`AC_P] <= main_operand_r[`AC_P] |
                                                         mem_data_r[`W_SIGN];
                                main_operand_r[34:0]  <= main_operand_r[34:0] |
                                                         mem_data_r[34:0];
                            end
                            `OP_COMPL_MAG: begin
                                main_operand_r[`AC_Q:`AC_P] <= add_sum[37:36];
                                main_operand_r[34:0]        <= add_sum[34:0];
                            end
                            `OP_PLACE_CHAR: begin
                                main_operand_r <= add_sum[37:0];
                            end
                            `OP_STORE_CHAR: begin
                                mem_wdata_o <= merged;
                                mem_wr_o    <= 1'b1;
                            end
                            default: begin
                                main_operand_r <= main_operand_r;
                            end
                        endcase
                    end
                end
                `ST_PASS2: begin
                    steps_r      <= lt ? 2'h2 : (le ? 2'h1 : 2'h0);
                    skip_count_o <= lt ? 2'h2 : (le ? 2'h1 : 2'h0);
                end
                `ST_WRITE: begin
                    if (mem_ack_i) begin
                        mem_wr_o <= 1'b0;
                    end
                end
                `ST_STEP: begin
                    if (steps_r != 2'h0) begin
                        ic_step_o <= 1'b1;
                        steps_r   <= steps_r - 2'h1;
                    end
                end
                `ST_DONE: begin
                    done_o <= 1'b1;
                end
                default: begin
                    mem_rd_o <= 1'b0;
                end
            endcase
            ac_o <= (state_r == `ST_IDLE && !op_start_i && ac_load_i) ?
                    ac_load_data_i : main_operand_r;
        end
    end

endmodule // logic_char_unit

// ==== verilog/word_adder.v ====
/*
 * plain binary adder with carry in; the full sum including the
 * carry out is returned so callers can tap any carry position.
 * assumes operands come from registers on the same clock.
 */
`timescale 1ns/1ps

module word_adder #(
    parameter WIDTH = 38
) (
    // operands
    input  wire [WIDTH-1:0] a_i,
    input  wire [WIDTH-1:0] b_i,
    input  wire             cin_i,
    // result, one bit wider than the operands
    output wire [WIDTH:0]   sum_o
);

    assign sum_o = {1'b0, a_i} + {1'b0, b_i} + {{WIDTH{1'b0}}, cin_i};

endmodule // word_adder
